// ---- dtp_defs.svh ----
`ifndef DTP_DEFS_SVH
`define DTP_DEFS_SVH

// APB register byte offsets
`define DTP_ADDR_CTRL      12'h000
`define DTP_ADDR_ON_DELAY  12'h004
`define DTP_ADDR_OFF_DELAY 12'h008
`define DTP_ADDR_STATUS    12'h00C
`define DTP_ADDR_ON_TIME   12'h010
`define DTP_ADDR_OFF_TIME  12'h014
`define DTP_ADDR_ON_REF    12'h018
`define DTP_ADDR_OFF_REF   12'h01C
`define DTP_ADDR_PRESCALE  12'h020

// Control field positions
`define DTP_CTRL_ON_INV     0
`define DTP_CTRL_OFF_INV    1
`define DTP_CTRL_CLR_INV    2
`define DTP_CTRL_ON_RETAIN  3
`define DTP_CTRL_OFF_RETAIN 4
`define DTP_CTRL_ON_SRC     5
`define DTP_CTRL_OFF_SRC    6
`define DTP_CTRL_ON_BASE    8
`define DTP_CTRL_OFF_BASE   10
`define DTP_CTRL_ON_SEL     16
`define DTP_CTRL_OFF_SEL    24

// Reset values
`define DTP_CTRL_RST     32'h0000_0000
`define DTP_DELAY_RST    16'h000A

// Reference value multipliers
`define DTP_MUL_MIN_BASE 60
`define DTP_MUL_SEC_BASE 100

// Time base tick: 10 ms at 100 MHz
`define DTP_CLK_PERIOD_NS 10
`define DTP_TICK_NS       10000000
`define DTP_TICK_CYCLES   (`DTP_TICK_NS / `DTP_CLK_PERIOD_NS)

`endif

// ---- dtp_pkg.sv ----
package dtp_pkg;
   // Time base of a timer's current time
   typedef enum logic [1:0] {
      DTP_BASE_SEC,
      DTP_BASE_MIN,
      DTP_BASE_HOUR
   } dtp_base_e;

   typedef enum logic [1:0] {
      DTP_IDLE,
      DTP_TIMING,
      DTP_HOLD
   } dtp_state_e;

   typedef logic [15:0] dtp_time_t;
endpackage

// ---- dtp_on_delay.sv ----
`timescale 1ns/1ns
`include "dtp_defs.svh"

module dtp_on_delay (
   // Clock and control
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   input  wire logic             en_in,
   input  wire logic             tick_in,
   input  wire logic             power_fail_in,
   input  wire logic             retain_in,
   // Trigger and delay
   input  wire logic             trg_in,
   input  wire dtp_pkg::dtp_time_t delay_in,
   // Results
   output logic                  q_out,
   output dtp_pkg::dtp_time_t    elapsed_time_out
);
   import dtp_pkg::*;

   dtp_state_e state_q, state_d;
   dtp_time_t  elapsed_q, elapsed_d;
   logic       trg_q, trg_d;
   logic       q_d;

   always_comb begin
      state_d   = state_q;
      elapsed_d = elapsed_q;
      trg_d     = trg_in;
      q_d       = q_out;
      if (power_fail_in && !retain_in) begin
         state_d   = DTP_IDLE;
         elapsed_d = '0;
         q_d       = 1'b0;
         trg_d     = 1'b0;
      end else if (power_fail_in) begin
         // Retained: everything frozen until power returns
         trg_d = trg_q;
      end else if (!trg_in) begin
         state_d   = DTP_IDLE;
         elapsed_d = '0;
         q_d       = 1'b0;
      end else if (!trg_q) begin
         state_d   = DTP_TIMING;
         elapsed_d = '0;
         q_d       = (delay_in == '0);
      end else begin
         unique case (state_q)
            DTP_IDLE: begin
               // Level held high from a retained start: resume
               state_d = DTP_TIMING;
            end
            DTP_TIMING: begin
               if (tick_in && elapsed_q != 16'hFFFF)
                  elapsed_d = elapsed_q + 16'h0001;
               if (elapsed_d >= delay_in) begin
                  state_d = DTP_HOLD;
                  q_d     = 1'b1;
               end
            end
            DTP_HOLD: begin
               q_d = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         state_q          <= DTP_IDLE;
         elapsed_q        <= '0;
         trg_q            <= 1'b0;
         q_out            <= 1'b0;
      end else if (en_in) begin
         state_q          <= state_d;
         elapsed_q        <= elapsed_d;
         trg_q            <= trg_d;
         q_out            <= q_d;
      end
   end

   assign elapsed_time_out = elapsed_q;
endmodule

// ---- dtp_off_delay.sv ----
`timescale 1ns/1ns
`include "dtp_defs.svh"

module dtp_off_delay (
   // Clock and control
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   input  wire logic             en_in,
   input  wire logic             tick_in,
   input  wire logic             power_fail_in,
   input  wire logic             retain_in,
   // Trigger, clear and delay
   input  wire logic             trg_in,
   input  wire logic             clr_in,
   input  wire dtp_pkg::dtp_time_t delay_in,
   // Results
   output logic                  q_out,
   output dtp_pkg::dtp_time_t    elapsed_time_out
);
   import dtp_pkg::*;

   dtp_state_e state_q, state_d;
   dtp_time_t  elapsed_q, elapsed_d;
   logic       trg_q, trg_d;
   logic       q_d;

   always_comb begin
      state_d   = state_q;
      elapsed_d = elapsed_q;
      trg_d     = trg_in;
      q_d       = q_out;
      if (power_fail_in && !retain_in) begin
         state_d   = DTP_IDLE;
         elapsed_d = '0;
         q_d       = 1'b0;
         trg_d     = 1'b0;
      end else if (power_fail_in) begin
         trg_d = trg_q;
      end else if (clr_in) begin
         state_d   = DTP_IDLE;
         elapsed_d = '0;
         q_d       = 1'b0;
      end else if (trg_in) begin
         // High trigger holds the output on; a new pulse rearms the delay
         state_d   = DTP_HOLD;
         elapsed_d = '0;
         q_d       = 1'b1;
      end else if (trg_q) begin
         state_d   = DTP_TIMING;
         elapsed_d = '0;
         q_d       = (delay_in != '0);
         if (delay_in == '0)
            state_d = DTP_IDLE;
      end else begin
         unique case (state_q)
            DTP_IDLE: begin
               q_d = 1'b0;
            end
            DTP_TIMING: begin
               if (tick_in && elapsed_q != 16'hFFFF)
                  elapsed_d = elapsed_q + 16'h0001;
               if (elapsed_d >= delay_in) begin
                  state_d = DTP_IDLE;
                  q_d     = 1'b0;
               end
            end
            DTP_HOLD: begin
               // Trigger dropped while frozen: start the delay now
               state_d   = DTP_TIMING;
               elapsed_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         state_q   <= DTP_IDLE;
         elapsed_q <= '0;
         trg_q     <= 1'b0;
         q_out     <= 1'b0;
      end else if (en_in) begin
         state_q   <= state_d;
         elapsed_q <= elapsed_d;
         trg_q     <= trg_d;
         q_out     <= q_d;
      end
   end

   assign elapsed_time_out = elapsed_q;
endmodule

// ---- dtp_delay_timer_pair.sv ----
`timescale 1ns/1ns
`include "dtp_defs.svh"

module dtp_delay_timer_pair #(
   parameter int unsigned TICK_CYCLES = `DTP_TICK_CYCLES,
   parameter int unsigned NUM_SRC     = 8
) (
   // Clock, reset, enable
   input  wire logic                     clk_in,
   input  wire logic                     nrst_in,
   input  wire logic                     en_in,
   // Power state
   input  wire logic                     power_fail_in,
   // Logic inputs from other blocks and their connection flags
   input  wire logic                     on_trg_in,
   input  wire logic                     on_trg_conn_in,
   input  wire logic                     off_trg_in,
   input  wire logic                     off_trg_conn_in,
   input  wire logic                     off_clr_in,
   input  wire logic                     off_clr_conn_in,
   // Actual values of other special function blocks
   input  wire logic [NUM_SRC*16-1:0]    special_function_block_val_in,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Outputs to other blocks
   output logic                          on_q_out,
   output logic                          off_q_out
);
   import dtp_pkg::*;

   localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   // ==========================================================
   // Registers
   // ==========================================================
   logic [31:0] ctrl_q, ctrl_d;
   dtp_time_t   on_delay_q, on_delay_d, off_delay_q, off_delay_d;
   logic [31:0] prdata_d;
   logic        pready_d, pslverr_d;

   // ==========================================================
   // Reference value conversion
   // ==========================================================
   function automatic dtp_time_t ref_value(input dtp_time_t t, input logic [1:0] base);
      logic [15:0] mul;
      logic [31:0] full;
      mul  = (base == DTP_BASE_SEC) ? 16'(`DTP_MUL_SEC_BASE) : 16'(`DTP_MUL_MIN_BASE);
      full = 32'(t[15:8]) * 32'(mul) + 32'(t[7:0]);
      return full[15:0];
   endfunction

   function automatic dtp_time_t pick_src(input logic [7:0] sel,
                                          input logic [NUM_SRC*16-1:0] vals);
      dtp_time_t r;
      r = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (sel == 8'(i))
            r = vals[i*16 +: 16];
      end
      return r;
   endfunction

   // ==========================================================
   // Input conditioning
   // ==========================================================
   logic on_trg_c, off_trg_c, off_clr_c;
   assign on_trg_c  = (on_trg_in  & on_trg_conn_in)  ^ ctrl_q[`DTP_CTRL_ON_INV];
   assign off_trg_c = (off_trg_in & off_trg_conn_in) ^ ctrl_q[`DTP_CTRL_OFF_INV];
   assign off_clr_c = (off_clr_in & off_clr_conn_in) ^ ctrl_q[`DTP_CTRL_CLR_INV];

   dtp_time_t on_delay_eff, off_delay_eff;
   assign on_delay_eff  = ctrl_q[`DTP_CTRL_ON_SRC] ?
      pick_src(ctrl_q[`DTP_CTRL_ON_SEL +: 8], special_function_block_val_in) : on_delay_q;
   assign off_delay_eff = ctrl_q[`DTP_CTRL_OFF_SRC] ?
      pick_src(ctrl_q[`DTP_CTRL_OFF_SEL +: 8], special_function_block_val_in) : off_delay_q;

   // ==========================================================
   // Time base
   // ==========================================================
   logic [TW-1:0] tick_cnt_q, tick_cnt_d;
   logic          tick_q, tick_d;

   always_comb begin
      tick_d     = 1'b0;
      tick_cnt_d = tick_cnt_q;
      if (!power_fail_in) begin
         if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
            tick_cnt_d = '0;
            tick_d     = 1'b1;
         end else begin
            tick_cnt_d = tick_cnt_q + TW'(1);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else if (en_in) begin
         tick_cnt_q <= tick_cnt_d;
         tick_q     <= tick_d;
      end
   end

   // ==========================================================
   // Timers
   // ==========================================================
   logic      on_q, off_q;
   dtp_time_t on_time, off_time;

   dtp_on_delay u_on (
      .clk_in           (clk_in),
      .nrst_in          (nrst_in),
      .en_in            (en_in),
      .tick_in          (tick_q),
      .power_fail_in    (power_fail_in),
      .retain_in        (ctrl_q[`DTP_CTRL_ON_RETAIN]),
      .trg_in           (on_trg_c),
      .delay_in         (on_delay_eff),
      .q_out            (on_q),
      .elapsed_time_out (on_time)
   );

   dtp_off_delay u_off (
      .clk_in           (clk_in),
      .nrst_in          (nrst_in),
      .en_in            (en_in),
      .tick_in          (tick_q),
      .power_fail_in    (power_fail_in),
      .retain_in        (ctrl_q[`DTP_CTRL_OFF_RETAIN]),
      .trg_in           (off_trg_c),
      .clr_in           (off_clr_c),
      .delay_in         (off_delay_eff),
      .q_out            (off_q),
      .elapsed_time_out (off_time)
   );

   // Sub-blocks register their outputs, so these are flop-driven
   assign on_q_out  = on_q;
   assign off_q_out = off_q;

   // ==========================================================
   // APB slave
   // ==========================================================
   // Zero wait states: pready rises in the access cycle after setup
   always_comb begin
      ctrl_d      = ctrl_q;
      on_delay_d  = on_delay_q;
      off_delay_d = off_delay_q;
      prdata_d    = 32'h0000_0000;
      pready_d    = 1'b0;
      pslverr_d   = 1'b0;
      if (psel && !penable) begin
         pready_d = 1'b1;
         unique case (paddr)
            `DTP_ADDR_CTRL:      prdata_d = ctrl_q;
            `DTP_ADDR_ON_DELAY:  prdata_d = {16'h0000, on_delay_q};
            `DTP_ADDR_OFF_DELAY: prdata_d = {16'h0000, off_delay_q};
            `DTP_ADDR_STATUS:    prdata_d = {30'h0000_0000, off_q, on_q};
            `DTP_ADDR_ON_TIME:   prdata_d = {16'h0000, on_time};
            `DTP_ADDR_OFF_TIME:  prdata_d = {16'h0000, off_time};
            `DTP_ADDR_ON_REF:    prdata_d = {16'h0000,
               ref_value(on_time, ctrl_q[`DTP_CTRL_ON_BASE +: 2])};
            `DTP_ADDR_OFF_REF:   prdata_d = {16'h0000,
               ref_value(off_time, ctrl_q[`DTP_CTRL_OFF_BASE +: 2])};
            `DTP_ADDR_PRESCALE:  prdata_d = 32'(TICK_CYCLES);
            default:             pslverr_d = 1'b1;
         endcase
      end
      if (psel && penable && pready && pwrite && !pslverr) begin
         unique case (paddr)
            `DTP_ADDR_CTRL:      ctrl_d      = pwdata;
            `DTP_ADDR_ON_DELAY:  on_delay_d  = pwdata[15:0];
            `DTP_ADDR_OFF_DELAY: off_delay_d = pwdata[15:0];
            default:             ctrl_d      = ctrl_q;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         ctrl_q      <= `DTP_CTRL_RST;
         on_delay_q  <= `DTP_DELAY_RST;
         off_delay_q <= `DTP_DELAY_RST;
         prdata      <= 32'h0000_0000;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
      end else if (en_in) begin
         ctrl_q      <= ctrl_d;
         on_delay_q  <= on_delay_d;
         off_delay_q <= off_delay_d;
         prdata      <= prdata_d;
         pready      <= pready_d;
         pslverr     <= pslverr_d;
      end
   end
endmodule

// ---- dtp_chk_sva.sv ----
`timescale 1ns/1ns

// ====
// Checker on the top ports
module dtp_chk (
   // Clock and power
   input wire logic        clk_in,
   input wire logic        nrst_in,
   input wire logic        en_in,
   input wire logic        power_fail_in,
   // Timer inputs
   input wire logic        on_trg_in,
   input wire logic        on_trg_conn_in,
   input wire logic        off_trg_in,
   input wire logic        off_trg_conn_in,
   input wire logic        off_clr_in,
   input wire logic        off_clr_conn_in,
   // Bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Outputs
   input wire logic        on_q_out,
   input wire logic        off_q_out
);
   logic [2:0] inv_q;
   logic [2:0] inv_d;
   logic       on_eff;
   logic       off_eff;
   logic       clr_eff;
   logic       run;
   // Inversion bits shadowed from completed control writes
   always_comb begin
      inv_d = inv_q;
      if (psel && penable && pready && pwrite && paddr == 12'h000)
         inv_d = pwdata[2:0];
   end
   always_ff @(posedge clk_in) begin
      if (!nrst_in)
         inv_q <= 3'h0;
      else if (en_in)
         inv_q <= inv_d;
   end
   assign on_eff  = (on_trg_in & on_trg_conn_in) ^ inv_q[0];
   assign off_eff = (off_trg_in & off_trg_conn_in) ^ inv_q[1];
   assign clr_eff = (off_clr_in & off_clr_conn_in) ^ inv_q[2];
   // Power loss may freeze a retentive timer, so those cycles are exempt
   assign run     = en_in && !power_fail_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   on_low_a: assert property (run && !on_eff |=> !on_q_out)
      else $error("on output high with trigger low");
   on_rise_a: assert property ($rose(on_q_out) |-> $past(on_eff))
      else $error("on output rose without trigger");
   on_hold_a: assert property (on_q_out && run && on_eff |=> on_q_out)
      else $error("on output dropped with trigger high");
   off_set_a: assert property (run && off_eff && !clr_eff |=> off_q_out)
      else $error("off output not set by trigger");
   off_clr_a: assert property (run && clr_eff |=> !off_q_out)
      else $error("off output not cleared");
   off_fall_a: assert property ($fell(off_q_out) |->
      $past(!off_eff || clr_eff || power_fail_in))
      else $error("off output fell with trigger high");
   apb_ready_a: assert property (en_in && psel && !penable |=> pready)
      else $error("no ready after setup");
   apb_pulse_a: assert property (en_in && pready |=> !pready)
      else $error("ready longer than one cycle");
   apb_err_a: assert property (pready && psel && paddr > 12'h020 |-> pslverr)
      else $error("no error on unmapped address");
   apb_ok_a: assert property (pready && paddr <= 12'h020 && paddr[1:0] == 2'h0
      |-> !pslverr)
      else $error("error on mapped address");
endmodule

// ---- dtp_sfb_model.sv ----
`timescale 1ns/1ns

// ====
// Other blocks: slot 0 counts, slot i holds 2*i
module dtp_sfb_model #(
   parameter int NUM_SRC = 8
) (
   // Clock
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   // Actual values
   output logic [NUM_SRC*16-1:0] vals_out
);
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   always_comb begin
      cnt_d = cnt_q + 16'h0001;
      vals_out = '0;
      for (int i = 1; i < NUM_SRC; i++)
         vals_out[i*16+:16] = 16'(2 * i);
      vals_out[15:0] = cnt_q;
   end
   always_ff @(posedge clk_in) begin
      if (!nrst_in)
         cnt_q <= 16'h0000;
      else
         cnt_q <= cnt_d;
   end
endmodule

// ---- test_delay_timer_pair.sv ----
`timescale 1ns/1ns

module test_delay_timer_pair;
   localparam int TK = 4;
   logic         clk_in = 1'b0;
   logic         nrst_in, en_in, power_fail_in, on_trg_in, on_trg_conn_in;
   logic         off_trg_in, off_trg_conn_in, off_clr_in, off_clr_conn_in;
   logic         psel, penable, pwrite, pready, pslverr, on_q_out, off_q_out, er;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata, rd, t;
   logic [127:0] sfb_val;
   int           err_count, checks_done;
   // Rows: {connected, trigger, invert, expected output}
   logic [3:0]   rows [8] = '{4'hD, 4'h8, 4'hE, 4'hB, 4'h4, 4'h3, 4'h0, 4'h7};

   always #5 clk_in = ~clk_in;

   dtp_delay_timer_pair #(.TICK_CYCLES(TK), .NUM_SRC(8)) u_dut (
      .clk_in(clk_in), .nrst_in(nrst_in), .en_in(en_in), .power_fail_in(power_fail_in),
      .on_trg_in(on_trg_in), .on_trg_conn_in(on_trg_conn_in), .off_trg_in(off_trg_in),
      .off_trg_conn_in(off_trg_conn_in), .off_clr_in(off_clr_in),
      .off_clr_conn_in(off_clr_conn_in), .special_function_block_val_in(sfb_val),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .on_q_out(on_q_out), .off_q_out(off_q_out));
   dtp_sfb_model #(.NUM_SRC(8)) u_sfb (.clk_in(clk_in), .nrst_in(nrst_in),
      .vals_out(sfb_val));

   task automatic report_and_stop;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic do_reset;
      nrst_in <= 1'b0;
      cyc(6);
      nrst_in <= 1'b1;
   endtask
   // ====
   // Bus transfer; a hung slave ends the run
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         report_and_stop();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial begin
      {nrst_in, power_fail_in, psel, penable, pwrite} = 5'h0;
      {on_trg_in, on_trg_conn_in, off_trg_in, off_trg_conn_in} = 4'h0;
      {off_clr_in, off_clr_conn_in, paddr, pwdata} = 46'h0;
      en_in = 1'b1;
      err_count = 0;
      checks_done = 0;
      do_reset();
      apb(1'b1, 12'h004, 32'h0000_0001);
      foreach (rows[i]) begin
         apb(1'b1, 12'h000, {31'h0, rows[i][1]});
         on_trg_conn_in <= rows[i][3];
         on_trg_in <= rows[i][2];
         cyc(4 * TK);
         chk(on_q_out, rows[i][0]);
         apb(1'b0, 12'h00C, 32'h0);
         chk(rd[0], rows[i][0]);
      end
      // ====
      // Reset in mid-run, then register defaults
      do_reset();
      chk(on_q_out, 1'b0);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         chk(rd, (i == 1 || i == 2) ? 32'h0000_000A : 32'h0);
      end
      apb(1'b0, 12'h024, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk(rd, TK);
      {on_trg_conn_in, off_trg_conn_in, off_clr_conn_in} <= 3'h7;
      // ====
      // On-delay: early drop clears elapsed time
      apb(1'b1, 12'h004, 32'h0000_0003);
      on_trg_in <= 1'b1;
      cyc(2 * TK - 1);
      chk(on_q_out, 1'b0);
      on_trg_in <= 1'b0;
      cyc(1);
      on_trg_in <= 1'b1;
      cyc(2 * TK - 1);
      chk(on_q_out, 1'b0);
      cyc(2 * TK);
      chk(on_q_out, 1'b1);
      // ====
      // Off-delay: set, retrigger, time out, clear
      apb(1'b1, 12'h008, 32'h0000_0005);
      off_trg_in <= 1'b1;
      cyc(2);
      chk(off_q_out, 1'b1);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd[1], 1'b1);
      off_trg_in <= 1'b0;
      cyc(3 * TK);
      chk(off_q_out, 1'b1);
      off_trg_in <= 1'b1;
      cyc(1);
      off_trg_in <= 1'b0;
      cyc(4 * TK);
      chk(off_q_out, 1'b1);
      cyc(3 * TK);
      chk(off_q_out, 1'b0);
      off_clr_in <= 1'b1;
      off_trg_in <= 1'b1;
      cyc(3);
      chk(off_q_out, 1'b0);
      off_clr_in <= 1'b0;
      cyc(2);
      chk(off_q_out, 1'b1);
      off_trg_in <= 1'b0;
      cyc(TK);
      off_clr_in <= 1'b1;
      cyc(2);
      chk(off_q_out, 1'b0);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h01C, 32'h0);
      chk(rd, 32'h0);
      off_clr_in <= 1'b0;
      // ====
      // Delay from slot 2 of the other blocks (4 ticks)
      on_trg_in <= 1'b0;
      apb(1'b1, 12'h000, 32'h0002_0020);
      on_trg_in <= 1'b1;
      cyc(3 * TK - 1);
      chk(on_q_out, 1'b0);
      cyc(2 * TK + 2);
      chk(on_q_out, 1'b1);
      // ====
      // Retentive freeze, reference value, then non-retentive loss
      on_trg_in <= 1'b0;
      apb(1'b1, 12'h004, 32'h0000_0105);
      apb(1'b1, 12'h000, 32'h0000_0108);
      on_trg_in <= 1'b1;
      cyc(258 * TK);
      power_fail_in <= 1'b1;
      cyc(2);
      apb(1'b0, 12'h010, 32'h0);
      t = rd;
      chk(t >= 32'h0000_0100, 1'b1);
      cyc(40);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, t);
      apb(1'b0, 12'h018, 32'h0);
      chk(rd, t[15:8] * 60 + t[7:0]);
      apb(1'b1, 12'h000, 32'h0000_0008);
      apb(1'b0, 12'h018, 32'h0);
      chk(rd, t[15:8] * 100 + t[7:0]);
      power_fail_in <= 1'b0;
      cyc(8 * TK);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd > t, 1'b1);
      cyc(8 * TK);
      chk(on_q_out, 1'b1);
      apb(1'b1, 12'h000, 32'h0);
      power_fail_in <= 1'b1;
      cyc(3);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'h0);
      chk(on_q_out, 1'b0);
      power_fail_in <= 1'b0;
      cyc(4);
      report_and_stop();
   end
endmodule

bind dtp_delay_timer_pair dtp_chk u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
   .en_in(en_in), .power_fail_in(power_fail_in), .on_trg_in(on_trg_in),
   .on_trg_conn_in(on_trg_conn_in), .off_trg_in(off_trg_in),
   .off_trg_conn_in(off_trg_conn_in), .off_clr_in(off_clr_in),
   .off_clr_conn_in(off_clr_conn_in), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .on_q_out(on_q_out), .off_q_out(off_q_out));
